// file: adsp_map.svh
// register map, command layout and timing constants of the serial port
`ifndef ADSP_MAP_SVH
`define ADSP_MAP_SVH

`define ADSP_DATA_W          24
`define ADSP_FIFO_DEPTH      32

// command byte layout
`define ADSP_CMD_WEN_BIT     7
`define ADSP_CMD_RD_BIT      6
`define ADSP_RA_MSB          5
`define ADSP_CMD_LAST        5'h07

// register addresses
`define ADSP_RA_STATUS       6'h00
`define ADSP_RA_MODE         6'h01
`define ADSP_RA_DATA         6'h04
`define ADSP_RA_ID           6'h07

// register lengths in bits
`define ADSP_STATUS_BITS     5'h08
`define ADSP_MODE_BITS       5'h10
`define ADSP_DATA_BITS       5'h18
`define ADSP_ID_BITS         5'h10

// fields and reset values
`define ADSP_MODE_RST        16'h0000
`define ADSP_CLKSEL_LSB      2
`define ADSP_CLKSEL_MSB      3
`define ADSP_STATUS_RDY_BIT  7
// identity value is arbitrary
`define ADSP_ID_VALUE        16'h5A5A

// ready-high gap before a stale result is replaced
`define ADSP_CLK_MHZ         125
`define ADSP_RDY_GAP_NS      40
`define ADSP_RDY_GAP_CYC     ((`ADSP_RDY_GAP_NS * `ADSP_CLK_MHZ + 999) / 1000)
`define ADSP_GAP_CNT_W       4

`endif

// file: adsp_pkg.sv
// types shared by the serial port files
package adsp_pkg;

   typedef enum logic [1:0] {
      LNK_CMD = 2'b00,
      LNK_RD  = 2'b01,
      LNK_WR  = 2'b10
   } adsp_link_e;

   typedef enum logic [1:0] {
      RES_EMPTY = 2'b00,
      RES_READY = 2'b01,
      RES_GAP   = 2'b11
   } adsp_res_e;

   typedef enum logic [1:0] {
      CLK_SRC_INT     = 2'b00,
      CLK_SRC_INT_OUT = 2'b01,
      CLK_SRC_EXT     = 2'b11,
      CLK_SRC_XTAL    = 2'b10
   } adsp_clk_src_e;

endpackage : adsp_pkg

// file: adsp_fifo.sv
// synchronous fifo for conversion results
`timescale 1ns/1ps
`include "adsp_map.svh"

module adsp_fifo #(
   parameter int WIDTH = `ADSP_DATA_W,
   parameter int DEPTH = `ADSP_FIFO_DEPTH
) (
   input  wire logic             clk,       // system clock
   input  wire logic             rst,       // synchronous reset, high
   input  wire logic             ce,        // clock enable
   input  wire logic [WIDTH-1:0] in_data,   // write word
   input  wire logic             in_valid,  // write request
   output logic                  in_ready,  // space available
   output logic      [WIDTH-1:0] out_data,  // head word
   output logic                  out_valid, // head word present
   input  wire logic             out_ready  // consumer takes head
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic [AW:0]      fill;

   assign fill      = wr_ptr_reg - rd_ptr_reg;
   assign in_ready  = fill != (AW+1)'(DEPTH);
   assign out_valid = fill != '0;
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (ce && in_valid && in_ready) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
      end else if (ce && in_valid && in_ready) begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ptr_reg <= '0;
      end else if (ce && out_valid && out_ready) begin
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

endmodule : adsp_fifo

// file: adsp_serial_port.sv
// converter serial host port with data-ready signalling and clock source select
`timescale 1ns/1ps
`include "adsp_map.svh"

module adsp_serial_port (
   input  wire logic                    clk,             // system clock, 125 MHz
   input  wire logic                    rst,             // synchronous reset, high
   input  wire logic                    ce,              // clock enable, freezes system side
   input  wire logic [`ADSP_DATA_W-1:0] conv_data,       // conversion result
   input  wire logic                    conv_valid,      // result offered
   output logic                         conv_ready,      // result accepted
   input  wire logic                    sclk,            // serial clock from host
   input  wire logic                    cs_n,            // chip select, low active
   input  wire logic                    din,             // serial data in
   output logic                         dout,            // serial data out / data ready
   output logic                         dout_oe,         // drive enable for dout
   input  wire logic                    int_osc_clk,     // internal oscillator clock
   output logic                         clk_pin_out,     // oscillator onto clock pin
   output logic                         clk_pin_oe,      // clock pin drive enable
   output logic                         osc_enable,      // internal oscillator on
   output logic                         xtal_amp_en,     // crystal amplifier on
   output logic [1:0]                   mclk_sel         // master clock mux select
);

   // ---------------- system side state ----------------
   logic                    rst_hold_reg;
   logic [15:0]             mode_reg;
   logic [`ADSP_DATA_W-1:0] result_reg;
   logic                    rdy_n_reg;
   adsp_pkg::adsp_res_e     res_state_reg;
   logic [`ADSP_GAP_CNT_W-1:0] gap_cnt_reg;
   logic [2:0]              wr_sync_reg;
   logic [2:0]              done_sync_reg;
   logic [1:0]              busy_sync_reg;
   logic                    osc_enable_reg;
   logic                    clk_pin_oe_reg;
   logic                    xtal_amp_en_reg;
   logic [1:0]              mclk_sel_reg;

   // ---------------- link side state ----------------
   adsp_pkg::adsp_link_e    link_state_reg;
   logic [4:0]              bit_cnt_reg;
   logic [`ADSP_DATA_W-1:0] in_sr_reg;
   logic [`ADSP_DATA_W-1:0] out_sr_reg;
   logic [`ADSP_RA_MSB:0]   cur_ra_reg;
   logic                    busy_reg;
   logic                    dout_reg;
   logic                    wr_tgl_reg;
   logic                    done_tgl_reg;
   logic [`ADSP_RA_MSB:0]   wr_addr_reg;
   logic [`ADSP_DATA_W-1:0] wr_data_reg;

   // ---------------- glue ----------------
   logic                    link_rst;
   logic                    frame_rst;
   logic [7:0]              cmd_byte;
   logic [`ADSP_RA_MSB:0]   cmd_ra;
   logic [`ADSP_DATA_W-1:0] in_word;
   logic                    wr_event;
   logic                    done_event;
   logic                    busy_s;
   logic [`ADSP_DATA_W-1:0] fifo_data;
   logic                    fifo_valid;
   logic                    load_ok;
   logic                    gap_done;
   adsp_pkg::adsp_clk_src_e clk_src;

   // length of each register as shifted on the wire
   function automatic logic [4:0] reg_bits(input logic [`ADSP_RA_MSB:0] ra);
      case (ra)
         `ADSP_RA_STATUS: reg_bits = `ADSP_STATUS_BITS;
         `ADSP_RA_MODE:   reg_bits = `ADSP_MODE_BITS;
         `ADSP_RA_DATA:   reg_bits = `ADSP_DATA_BITS;
         `ADSP_RA_ID:     reg_bits = `ADSP_ID_BITS;
         default:         reg_bits = `ADSP_STATUS_BITS;
      endcase
   endfunction : reg_bits

   // ---------------- fifo in the result path ----------------
   // the fifo is popped only when the result register may take a word
   adsp_fifo #(
      .WIDTH (`ADSP_DATA_W),
      .DEPTH (`ADSP_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_data   (conv_data),
      .in_valid  (conv_valid),
      .in_ready  (conv_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (load_ok)
   );

   // ---------------- resets for the link side ----------------
   // the serial clock only runs inside frames, so link state is
   // cleared asynchronously by chip select and by the system reset
   always_ff @(posedge clk) begin
      rst_hold_reg <= rst;
   end

   // link_rst keeps events across frames, frame_rst clears the decoder
   assign link_rst  = rst_hold_reg;
   assign frame_rst = cs_n | rst_hold_reg;

   // ---------------- link side: shifter and decoder ----------------
   assign cmd_byte = {in_sr_reg[6:0], din};
   assign cmd_ra   = cmd_byte[`ADSP_RA_MSB:0];
   assign in_word  = {in_sr_reg[`ADSP_DATA_W-2:0], din};

   // input shifter takes a bit on every rising edge while selected
   always_ff @(posedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         in_sr_reg <= '0;
      end else begin
         in_sr_reg <= in_word;
      end
   end

   always_ff @(posedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         link_state_reg <= adsp_pkg::LNK_CMD;
         bit_cnt_reg    <= '0;
         out_sr_reg     <= '0;
         cur_ra_reg     <= '0;
         busy_reg       <= 1'b0;
      end else begin
         case (link_state_reg)
            adsp_pkg::LNK_CMD: begin
               if (bit_cnt_reg != `ADSP_CMD_LAST) begin
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
               // top bit set: byte dropped, the next eight bits are a new command
               end else if (cmd_byte[`ADSP_CMD_WEN_BIT]) begin
                  bit_cnt_reg <= '0;
               end else begin
                  cur_ra_reg  <= cmd_ra;
                  bit_cnt_reg <= reg_bits(cmd_ra);
                  if (cmd_byte[`ADSP_CMD_RD_BIT]) begin
                     link_state_reg <= adsp_pkg::LNK_RD;
                     // busy holds off result loads while a data read shifts out
                     busy_reg       <= cmd_ra == `ADSP_RA_DATA;
                     case (cmd_ra)
                        `ADSP_RA_STATUS: out_sr_reg <= `ADSP_DATA_W'({rdy_n_reg, 7'h00});
                        `ADSP_RA_MODE:   out_sr_reg <= `ADSP_DATA_W'(mode_reg);
                        `ADSP_RA_DATA:   out_sr_reg <= result_reg;
                        `ADSP_RA_ID:     out_sr_reg <= `ADSP_DATA_W'(`ADSP_ID_VALUE);
                        default:         out_sr_reg <= '0;
                     endcase
                  end else begin
                     link_state_reg <= adsp_pkg::LNK_WR;
                  end
               end
            end
            adsp_pkg::LNK_RD: begin
               bit_cnt_reg <= bit_cnt_reg - 5'h01;
               if (bit_cnt_reg == 5'h01) begin
                  link_state_reg <= adsp_pkg::LNK_CMD;
                  busy_reg       <= 1'b0;
               end
            end
            adsp_pkg::LNK_WR: begin
               bit_cnt_reg <= bit_cnt_reg - 5'h01;
               if (bit_cnt_reg == 5'h01) begin
                  link_state_reg <= adsp_pkg::LNK_CMD;
               end
            end
            default: begin
               link_state_reg <= adsp_pkg::LNK_CMD;
               bit_cnt_reg    <= '0;
            end
         endcase
      end
   end

   // falling edge presents the next bit, host samples it on the rise
   always_ff @(negedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         dout_reg <= 1'b1;
      end else if (link_state_reg == adsp_pkg::LNK_RD) begin
         dout_reg <= out_sr_reg[bit_cnt_reg - 5'h01];
      end
   end

   // events handed to the system side; survive the end of the frame
   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         wr_tgl_reg  <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
      end else if (link_state_reg == adsp_pkg::LNK_WR && bit_cnt_reg == 5'h01) begin
         wr_addr_reg <= cur_ra_reg;
         wr_data_reg <= in_word;
         wr_tgl_reg  <= ~wr_tgl_reg;
      end
   end

   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         done_tgl_reg <= 1'b0;
      end else if (link_state_reg == adsp_pkg::LNK_RD && bit_cnt_reg == 5'h01
                   && cur_ra_reg == `ADSP_RA_DATA) begin
         done_tgl_reg <= ~done_tgl_reg;
      end
   end

   // ---------------- pin: shared data and ready line ----------------
   // outside a read the line carries the ready flag, low while a result waits
   assign dout    = (link_state_reg == adsp_pkg::LNK_RD) ? dout_reg : rdy_n_reg;
   assign dout_oe = ~cs_n;

   // ---------------- system side: crossings ----------------
   // toggle handshakes: address and data load on the same serial clock edge as their toggle and are stable before it is synchronized
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_sync_reg   <= '0;
         done_sync_reg <= '0;
         busy_sync_reg <= '0;
      end else if (ce) begin
         wr_sync_reg   <= {wr_sync_reg[1:0], wr_tgl_reg};
         done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
         busy_sync_reg <= {busy_sync_reg[0], busy_reg};
      end
   end

   assign wr_event   = wr_sync_reg[2] ^ wr_sync_reg[1];
   assign done_event = done_sync_reg[2] ^ done_sync_reg[1];
   assign busy_s     = busy_sync_reg[1];

   // ---------------- system side: register writes ----------------
   // writes to read-only or unmapped addresses are dropped
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= `ADSP_MODE_RST;
      end else if (ce && wr_event && wr_addr_reg == `ADSP_RA_MODE) begin
         mode_reg <= wr_data_reg[15:0];
      end
   end

   // ---------------- system side: clock source ----------------
   // the source code is the field itself, no decode
   assign clk_src = adsp_pkg::adsp_clk_src_e'(mode_reg[`ADSP_CLKSEL_MSB:`ADSP_CLKSEL_LSB]);

   always_ff @(posedge clk) begin
      if (rst) begin
         osc_enable_reg  <= 1'b1;
         clk_pin_oe_reg  <= 1'b0;
         xtal_amp_en_reg <= 1'b0;
         mclk_sel_reg    <= adsp_pkg::CLK_SRC_INT;
      end else if (ce) begin
         osc_enable_reg  <= clk_src == adsp_pkg::CLK_SRC_INT
                         || clk_src == adsp_pkg::CLK_SRC_INT_OUT;
         clk_pin_oe_reg  <= clk_src == adsp_pkg::CLK_SRC_INT_OUT;
         xtal_amp_en_reg <= clk_src == adsp_pkg::CLK_SRC_XTAL;
         mclk_sel_reg    <= clk_src;
      end
   end

   assign osc_enable  = osc_enable_reg;
   assign clk_pin_oe  = clk_pin_oe_reg;
   assign xtal_amp_en = xtal_amp_en_reg;
   assign mclk_sel    = mclk_sel_reg;
   // oscillator forwarded to the pin only while the pin is driven
   assign clk_pin_out = int_osc_clk & clk_pin_oe_reg;

   // ---------------- system side: result and ready ----------------
   // a new result is not loaded while busy_s is high, from two clocks after a data read of the old one starts
   assign gap_done = gap_cnt_reg == `ADSP_GAP_CNT_W'(`ADSP_RDY_GAP_CYC - 1);
   assign load_ok  = ce && !busy_s
                  && (res_state_reg == adsp_pkg::RES_EMPTY
                      || (res_state_reg == adsp_pkg::RES_GAP && gap_done));

   always_ff @(posedge clk) begin
      if (rst) begin
         result_reg <= '0;
      end else if (load_ok && fifo_valid) begin
         result_reg <= fifo_data;
      end
   end

   // gap counter restarts whenever the gap state is left
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_cnt_reg <= '0;
      end else if (ce) begin
         if (res_state_reg != adsp_pkg::RES_GAP) begin
            gap_cnt_reg <= '0;
         end else if (!gap_done) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         res_state_reg <= adsp_pkg::RES_EMPTY;
         rdy_n_reg     <= 1'b1;
      end else if (ce) begin
         case (res_state_reg)
            adsp_pkg::RES_EMPTY: begin
               if (load_ok && fifo_valid) begin
                  res_state_reg <= adsp_pkg::RES_READY;
                  rdy_n_reg     <= 1'b0;
               end
            end
            adsp_pkg::RES_READY: begin
               if (done_event) begin
                  res_state_reg <= adsp_pkg::RES_EMPTY;
                  rdy_n_reg     <= 1'b1;
               end else if (fifo_valid) begin
                  res_state_reg <= adsp_pkg::RES_GAP;
                  rdy_n_reg     <= 1'b1;
               end
            end
            adsp_pkg::RES_GAP: begin
               if (gap_done && load_ok && fifo_valid) begin
                  res_state_reg <= adsp_pkg::RES_READY;
                  rdy_n_reg     <= 1'b0;
               end
            end
            default: begin
               res_state_reg <= adsp_pkg::RES_EMPTY;
               rdy_n_reg     <= 1'b1;
            end
         endcase
      end
   end

endmodule : adsp_serial_port

// file: adsp_serial_port_properties.sv
// concurrent checks on the serial port pins
`timescale 1ns/1ps

module adsp_sp_props (
   input wire logic       clk,         // clock
   input wire logic       rst,         // reset
   input wire logic       ce,          // enable
   input wire logic       conv_valid,  // offered
   input wire logic       conv_ready,  // room
   input wire logic       sclk,        // link clock
   input wire logic       cs_n,        // select
   input wire logic       dout,        // data out
   input wire logic       dout_oe,     // drive
   input wire logic       int_osc_clk, // oscillator
   input wire logic       clk_pin_out, // pin clock
   input wire logic       clk_pin_oe,  // pin drive
   input wire logic       osc_enable,  // osc on
   input wire logic       xtal_amp_en, // amp on
   input wire logic [1:0] mclk_sel     // source
);
   logic       sclk_reg;
   logic [7:0] quiet_cnt_reg;
   logic       quiet;

   // cycles since the serial clock last moved
   always_ff @(posedge clk) begin
      sclk_reg <= sclk;
      if (rst || sclk != sclk_reg) quiet_cnt_reg <= 8'h00;
      else if (quiet_cnt_reg != 8'hFF) quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
   end
   assign quiet = quiet_cnt_reg >= 8'h18;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_new_result;
      quiet && !cs_n && $fell(dout);
   endsequence
   sequence s_shows_ready;
      ##[1:12] (!dout || !quiet);
   endsequence

   property p_oe_cs;
      dout_oe == !cs_n;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("data out drive does not follow select");
   property p_pin_fwd;
      clk_pin_out == (clk_pin_oe && int_osc_clk);
   endproperty
   a_pin_fwd: assert property (p_pin_fwd)
      else $error("clock pin output wrong");
   property p_src_map;
      osc_enable == (mclk_sel == adsp_pkg::CLK_SRC_INT || mclk_sel == adsp_pkg::CLK_SRC_INT_OUT)
      && clk_pin_oe == (mclk_sel == adsp_pkg::CLK_SRC_INT_OUT) && xtal_amp_en == (mclk_sel == adsp_pkg::CLK_SRC_XTAL);
   endproperty
   a_src_map: assert property (p_src_map)
      else $error("clock enables do not match source");
   property p_rst_src;
      $fell(rst) |-> mclk_sel == 2'b00 && osc_enable && !clk_pin_oe && !xtal_amp_en;
   endproperty
   a_rst_src: assert property (p_rst_src)
      else $error("clock source not at reset value");
   property p_rst_port;
      $fell(rst) |-> dout && conv_ready;
   endproperty
   a_rst_port: assert property (p_rst_port)
      else $error("port not idle after reset");
   property p_gap;
      s_new_result |-> $past(dout, 4);
   endproperty
   a_gap: assert property (p_gap)
      else $error("ready fell without a high gap");
   property p_rdy_take;
      conv_valid && conv_ready && ce && dout && quiet && !cs_n |-> s_shows_ready;
   endproperty
   a_rdy_take: assert property (p_rdy_take)
      else $error("ready did not fall after a result");
   property p_cfg_hold;
      $changed(mclk_sel) |-> quiet_cnt_reg < 8'h10;
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("clock source moved without a write");
endmodule : adsp_sp_props

// file: adsp_host.sv
// host model: serial clock, select and data in
`timescale 1ns/1ps

module adsp_host (
   output logic      sclk,   // serial clock
   output logic      cs_n,   // select
   output logic      din,    // data in
   input  wire logic dout,   // device data
   input  wire logic dout_oe // device drive
);
   logic line;
   logic last_reg;

   // a released line shows the inverse of its last driven level
   always @(dout, dout_oe) begin
      if (dout_oe) last_reg = dout;
   end
   assign line = dout_oe ? dout : ~last_reg;

   // select rises after time zero so the frame reset sees a real edge
   initial begin
      last_reg = 1'b0;
      sclk = 1'b1;
      din = 1'b1;
      #1 cs_n = 1'b1;
   end

   // drive on the falling edge, sample just before the rising edge
   task automatic shift(input logic b, output logic v);
      #80 sclk = 1'b0;
      din = b;
      #80 v = line;
      sclk = 1'b1;
   endtask : shift

   // command byte then n bits msb first; hold keeps select low
   task automatic frame(input logic [7:0] cmd, input int n, input logic [23:0] wd, input bit hold,
                        output logic [23:0] rd);
      logic v;
      rd = 24'h000000;
      #3 cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) shift(cmd[i], v);
      for (int i = n - 1; i >= 0; i--) begin
         shift(wd[i], v);
         rd = {rd[22:0], v};
      end
      #80 cs_n = !hold;
   endtask : frame

   // wait for the line to reach a level, used as the ready interrupt
   task automatic wait_level(input logic lvl, output bit ok);
      cs_n = 1'b0;
      #8;
      for (int i = 0; i < 4000 && line !== lvl; i++) #8;
      ok = line === lvl;
   endtask : wait_level
endmodule : adsp_host

// file: adc_serial_port_and_clock_select_test.sv
// self-checking bench for the converter serial port
`timescale 1ns/1ps
`include "adsp_map.svh"

module adc_serial_port_and_clock_select_test;
   logic                    clk, rst, ce, conv_valid, conv_ready, sclk, cs_n, din, dout, dout_oe;
   logic                    int_osc_clk, clk_pin_out, clk_pin_oe, osc_enable, xtal_amp_en;
   logic [`ADSP_DATA_W-1:0] conv_data;
   logic [1:0]              mclk_sel;
   int                      miscompares;
   int                      checks;

   adsp_serial_port u_adsp_serial_port (
      .clk(clk), .rst(rst), .ce(ce), .conv_data(conv_data), .conv_valid(conv_valid),
      .conv_ready(conv_ready), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
      .int_osc_clk(int_osc_clk), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
      .osc_enable(osc_enable), .xtal_amp_en(xtal_amp_en), .mclk_sel(mclk_sel));
   adsp_host u_adsp_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      int_osc_clk = 1'b0;
      #3;
      forever #10 int_osc_clk = ~int_osc_clk;
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   function automatic logic [2:0] src_exp(input logic [1:0] c);
      return {c == adsp_pkg::CLK_SRC_INT || c == adsp_pkg::CLK_SRC_INT_OUT,
              c == adsp_pkg::CLK_SRC_INT_OUT, c == adsp_pkg::CLK_SRC_XTAL};
   endfunction : src_exp

   // offer one result until the port takes it
   task automatic push(input logic [23:0] w);
      @(posedge clk) #1;
      conv_data = w;
      conv_valid = 1'b1;
      // ready is settled between edges; the word goes at the next edge while it is high
      for (int i = 0; i < 100 && conv_ready !== 1'b1; i++) @(posedge clk) #1;
      @(posedge clk) #1;
      conv_valid = 1'b0;
   endtask : push

   initial begin
      #300000;
      miscompares++;
      print_verdict();
   end

   initial begin
      logic [23:0] got, w;
      logic [15:0] m;
      bit          ok;
      rst = 1'b1;
      ce = 1'b1;
      conv_valid = 1'b0;
      conv_data = 24'h000000;
      miscompares = 0;
      checks = 0;
      void'($urandom(52));
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      check("drive idle", 24'(dout_oe), 24'h0);
      u_adsp_host.frame({2'b01, `ADSP_RA_ID}, 16, 24'h0, 1'b0, got);
      check("id", got, {8'h00, `ADSP_ID_VALUE});
      $display("test id done");
      for (int c = 0; c < 4; c++) begin
         m = 16'($urandom());
         m[`ADSP_CLKSEL_MSB:`ADSP_CLKSEL_LSB] = c[1:0];
         u_adsp_host.frame({2'b00, `ADSP_RA_MODE}, 16, {8'h00, m}, 1'b0, got);
         repeat (10) @(posedge clk);
         check("source", 24'(mclk_sel), 24'(c[1:0]));
         check("enables", 24'({osc_enable, clk_pin_oe, xtal_amp_en}), 24'(src_exp(c[1:0])));
         u_adsp_host.frame({2'b01, `ADSP_RA_MODE}, 16, 24'h0, 1'b0, got);
         check("mode", got, 24'(m));
      end
      $display("test source done");
      for (int k = 0; k < 3; k++) begin
         w = k == 0 ? 24'hFFFFFF : k == 1 ? 24'h000000 : 24'($urandom());
         push(w);
         u_adsp_host.wait_level(1'b0, ok);
         check("ready", 24'(ok), 24'h1);
         u_adsp_host.frame({2'b01, `ADSP_RA_STATUS}, 8, 24'h0, 1'b1, got);
         check("status", got, 24'h0);
         u_adsp_host.frame({2'b01, `ADSP_RA_DATA}, 24, 24'h0, 1'b1, got);
         check("result", got, w);
         repeat (10) @(posedge clk);
         u_adsp_host.frame({2'b01, `ADSP_RA_STATUS}, 8, 24'h0, k != 2, got);
         check("status read", got, 24'h80);
      end
      $display("test result done");
      push(24'($urandom()));
      u_adsp_host.wait_level(1'b0, ok);
      w = 24'($urandom());
      push(w);
      u_adsp_host.wait_level(1'b1, ok);
      check("ready gap", 24'(ok), 24'h1);
      u_adsp_host.wait_level(1'b0, ok);
      u_adsp_host.frame({2'b01, `ADSP_RA_DATA}, 24, 24'h0, 1'b0, got);
      check("newer result", got, w);
      $display("test replace done");
      repeat (20) @(posedge clk);
      u_adsp_host.wait_level(1'b1, ok);
      check("idle ready", 24'(ok), 24'h1);
      ok = 1'b0;
      @(posedge clk) #1;
      conv_valid = 1'b1;
      for (int i = 0; i < 80 && !ok; i++) begin
         conv_data = 24'($urandom());
         ok = conv_ready !== 1'b1;
         if (!ok) w = conv_data;
         @(posedge clk) #1;
      end
      conv_valid = 1'b0;
      check("fifo refused", 24'(ok), 24'h1);
      repeat (600) @(posedge clk);
      check("fifo drained", 24'(conv_ready), 24'h1);
      u_adsp_host.wait_level(1'b0, ok);
      u_adsp_host.frame({2'b01, `ADSP_RA_DATA}, 24, 24'h0, 1'b0, got);
      check("last result", got, w);
      #1 check("drive released", 24'(dout_oe), 24'h0);
      $display("test fill done");
      print_verdict();
   end
endmodule : adc_serial_port_and_clock_select_test

bind adsp_serial_port adsp_sp_props u_adsp_sp_props (
   .clk(clk), .rst(rst), .ce(ce), .conv_valid(conv_valid), .conv_ready(conv_ready), .sclk(sclk),
   .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .int_osc_clk(int_osc_clk), .clk_pin_out(clk_pin_out),
   .clk_pin_oe(clk_pin_oe), .osc_enable(osc_enable), .xtal_amp_en(xtal_amp_en), .mclk_sel(mclk_sel));
